// File: hw/subw_core.sv
`default_nettype none
// Overview of operation
// - destination clear: file minus W goes into W, file untouched
// - destination set: difference written back to the file register, W kept
// - access clear: address lies in the access bank, bank pointer ignored
// - access set: bank pointer register and operand form the full address
// - extended set, access clear, operand up to 5Fh: indexed literal offset
// - one word, four phases: decode, read file, process, write destination
module subw_core
   import subw_pkg::*;
(
   input  wire logic                      core_clk,
   input  wire logic                      rstn,
   input  wire logic [15:0]               instrWord,
   input  wire logic                      instrValid,
   input  wire logic                      extSetEn,
   input  wire logic [subw_pkg::BANK_W-1:0] bankPtr,
   input  wire logic [subw_pkg::ADDR_W-1:0] indexBase,
   input  wire logic                      wregLoad,
   input  wire logic [subw_pkg::DATA_W-1:0] wregLoadData,
   input  wire logic                      fileLoad,
   input  wire logic [subw_pkg::ADDR_W-1:0] fileLoadAddr,
   input  wire logic [subw_pkg::DATA_W-1:0] fileLoadData,
   input  wire logic [subw_pkg::ADDR_W-1:0] peekAddr,
   output logic      [subw_pkg::DATA_W-1:0] peekData,
   output logic      [subw_pkg::DATA_W-1:0] wregValue,
   output subw_pkg::subw_flags_t          statusFlags,
   output subw_pkg::subw_phase_t          phase,
   output logic                           instrReady,
   output logic                           instrDone,
   output logic                           instrRejected
);
   import subw_pkg::*;

   subw_phase_t           phase_reg, phase_next;
   logic                  busy_reg, busy_next;
   subw_op_t              op_reg, op_next;
   logic [DATA_W-1:0]     wreg_reg, wreg_next;
   logic [DATA_W-1:0]     result_reg, result_next;
   subw_flags_t           calc_reg, calc_next;
   subw_flags_t           flags_reg, flags_next;
   logic                  ready_reg, ready_next;
   logic                  done_reg, done_next;
   logic                  rej_reg, rej_next;

   logic [DATA_W-1:0]     fileData;
   logic                  ramWrEn;
   logic [ADDR_W-1:0]     ramWrAddr;
   logic [DATA_W-1:0]     ramWrData;
   logic [7:0]            fOperand;
   logic                  isSubOp;
   logic                  writeBack;
   logic [ADDR_W-1:0]     effAddr;
   logic [DATA_W:0]       fullSum;
   logic [4:0]            nibSum;

   assign fOperand  = instrWord[FADDR_HI:FADDR_LO];
   assign isSubOp   = instrWord[OPC_HI:OPC_LO] == OPC_SUBTRACT;
   assign writeBack = busy_reg && (phase_reg == PH_WRITE);

   // effective file address
   always_comb begin
      if (instrWord[ACCESS_BIT]) begin
         effAddr = {bankPtr, fOperand};
      end else if (extSetEn && fOperand <= IDX_LIMIT) begin
         effAddr = indexBase + {{(ADDR_W-8){1'b0}}, fOperand};
      end else if (fOperand < ACC_SPLIT) begin
         effAddr = {ACC_LO_BANK, fOperand};
      end else begin
         effAddr = {ACC_HI_BANK, fOperand};
      end
   end

   // two's complement: f + ~W + 1, carry out is the no-borrow flag
   assign fullSum = {1'b0, fileData} + {1'b0, ~wreg_reg} + {{DATA_W{1'b0}}, 1'b1};
   assign nibSum  = {1'b0, fileData[3:0]} + {1'b0, ~wreg_reg[3:0]} + 5'h01;

   // instruction writes win over the load port in the same cycle
   assign ramWrEn   = (writeBack && op_reg.toFile) || fileLoad;
   assign ramWrAddr = (writeBack && op_reg.toFile) ? op_reg.addr : fileLoadAddr;
   assign ramWrData = (writeBack && op_reg.toFile) ? result_reg : fileLoadData;

   subw_file_ram #(
      .AW (ADDR_W),
      .DW (DATA_W)
   ) u_ram (
      .core_clk (core_clk),
      .wrEn     (ramWrEn),
      .wrAddr   (ramWrAddr),
      .wrData   (ramWrData),
      .rdAddr   (op_reg.addr),
      .rdData   (fileData),
      .peekAddr (peekAddr),
      .peekData (peekData)
   );

   always_comb begin
      phase_next  = phase_reg;
      busy_next   = busy_reg;
      op_next     = op_reg;
      wreg_next   = wreg_reg;
      result_next = result_reg;
      calc_next   = calc_reg;
      flags_next  = flags_reg;
      rej_next    = 1'b0;
      done_next   = 1'b0;
      case (phase_reg)
         PH_DECODE: begin
            phase_next = PH_READ;
            busy_next  = 1'b0;
            if (instrValid && isSubOp) begin
               busy_next      = 1'b1;
               op_next.toFile = instrWord[DEST_BIT];
               op_next.addr   = effAddr;
            end else if (instrValid) begin
               rej_next = 1'b1;
            end
         end
         PH_READ: begin
            phase_next = PH_PROC;
         end
         PH_PROC: begin
            phase_next  = PH_WRITE;
            result_next = fullSum[DATA_W-1:0];
            calc_next.carry          = fullSum[DATA_W];
            calc_next.digitCarryFlag = nibSum[4];
            calc_next.zero           = fullSum[DATA_W-1:0] == '0;
            calc_next.negative       = fullSum[DATA_W-1];
            calc_next.overflowFlag   = (fileData[DATA_W-1] != wreg_reg[DATA_W-1]) &&
                                       (fullSum[DATA_W-1] != fileData[DATA_W-1]);
         end
         PH_WRITE: begin
            phase_next = PH_DECODE;
            if (busy_reg) begin
               done_next  = 1'b1;
               flags_next = calc_reg;
            end
         end
         default: begin
            phase_next = PH_DECODE;
         end
      endcase
      if (writeBack && !op_reg.toFile) begin
         wreg_next = result_reg;
      end else if (wregLoad) begin
         wreg_next = wregLoadData;
      end
      ready_next = phase_next == PH_DECODE;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         phase_reg  <= PH_DECODE;
         busy_reg   <= 1'b0;
         op_reg     <= '0;
         wreg_reg   <= WREG_RST;
         result_reg <= '0;
         calc_reg   <= FLAGS_RST;
         flags_reg  <= FLAGS_RST;
         ready_reg  <= 1'b1;
         done_reg   <= 1'b0;
         rej_reg    <= 1'b0;
      end else begin
         phase_reg  <= phase_next;
         busy_reg   <= busy_next;
         op_reg     <= op_next;
         wreg_reg   <= wreg_next;
         result_reg <= result_next;
         calc_reg   <= calc_next;
         flags_reg  <= flags_next;
         ready_reg  <= ready_next;
         done_reg   <= done_next;
         rej_reg    <= rej_next;
      end
   end

   assign wregValue     = wreg_reg;
   assign statusFlags   = flags_reg;
   assign phase         = phase_reg;
   assign instrReady    = ready_reg;
   assign instrDone     = done_reg;
   assign instrRejected = rej_reg;

   // ---------------- assertions ----------------
   sequence s_accept;
      phase_reg == PH_DECODE && instrValid && isSubOp;
   endsequence

   sequence s_four_phases;
      phase_reg == PH_READ ##1 phase_reg == PH_PROC ##1 phase_reg == PH_WRITE
         ##1 phase_reg == PH_DECODE;
   endsequence

   AST_PHASE_ORDER: assert property (
      @(posedge core_clk) disable iff (!rstn)
      s_accept |=> s_four_phases)
      else $error("phase sequence broken");

   AST_DONE_TIMING: assert property (
      @(posedge core_clk) disable iff (!rstn)
      s_accept |-> ##3 (!instrDone) ##1 instrDone)
      else $error("done not four cycles after accept");

   AST_W_DEST: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (writeBack && !op_reg.toFile) |=> wreg_reg == $past(result_reg))
      else $error("W not loaded with difference");

   AST_FILE_KEEP_W: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (writeBack && op_reg.toFile && !wregLoad) |=> $stable(wreg_reg))
      else $error("W changed on file destination");

   AST_FILE_WRITE: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (writeBack && op_reg.toFile) |-> ramWrEn && ramWrAddr == op_reg.addr
         && ramWrData == result_reg)
      else $error("file write-back missing");

   AST_BANKED: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (s_accept and instrWord[ACCESS_BIT]) |=> op_reg.addr == {$past(bankPtr), $past(fOperand)})
      else $error("banked address wrong");

   AST_ACCESS: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (s_accept and !instrWord[ACCESS_BIT] && !extSetEn) |=>
         op_reg.addr[ADDR_W-1:8] == ($past(fOperand[7]) ? ACC_HI_BANK : ACC_LO_BANK))
      else $error("access bank address wrong");

   AST_INDEXED: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (s_accept and !instrWord[ACCESS_BIT] && extSetEn && fOperand <= IDX_LIMIT) |=>
         op_reg.addr == $past(indexBase) + {4'h0, $past(fOperand)})
      else $error("indexed address wrong");

   AST_CARRY: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (busy_reg && phase_reg == PH_PROC) |=>
         calc_reg.carry == ($past(fileData) >= $past(wreg_reg)))
      else $error("carry does not mean no borrow");

   AST_ZERO: assert property (
      @(posedge core_clk) disable iff (!rstn)
      instrDone |-> statusFlags.zero == ($past(result_reg) == '0))
      else $error("zero flag wrong");

   AST_REJECT: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (phase_reg == PH_DECODE && instrValid && !isSubOp) |=> instrRejected && !busy_reg)
      else $error("foreign opcode not rejected");
endmodule
`default_nettype wire

// File: hw/subw_file_ram.sv
`default_nettype none
module subw_file_ram #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   input  wire logic          core_clk,
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [DW-1:0] wrData,
   input  wire logic [AW-1:0] rdAddr,
   output logic      [DW-1:0] rdData,
   input  wire logic [AW-1:0] peekAddr,
   output logic      [DW-1:0] peekData
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // no reset: contents are undefined until written, like real data ram
   always_ff @(posedge core_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData   <= mem[rdAddr];
      peekData <= mem[peekAddr];
   end
endmodule
`default_nettype wire

// File: hw/subw_pkg.sv
`default_nettype none
package subw_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int BANK_W = 4;

   // opcode field layout
   localparam int          OPC_HI      = 15;
   localparam int          OPC_LO      = 10;
   localparam logic [5:0]  OPC_SUBTRACT = 6'h17;
   localparam int          DEST_BIT    = 9;
   localparam int          ACCESS_BIT  = 8;
   localparam int          FADDR_HI    = 7;
   localparam int          FADDR_LO    = 0;

   // access bank split and indexed window
   localparam logic [7:0]  ACC_SPLIT   = 8'h80;
   localparam logic [7:0]  IDX_LIMIT   = 8'h5F;
   localparam logic [3:0]  ACC_LO_BANK = 4'h0;
   localparam logic [3:0]  ACC_HI_BANK = 4'hF;

   localparam logic [7:0]  WREG_RST    = 8'h00;

   typedef enum logic [1:0] {
      PH_DECODE,
      PH_READ,
      PH_PROC,
      PH_WRITE
   } subw_phase_t;

   typedef struct packed {
      logic negative;
      logic overflowFlag;
      logic zero;
      logic digitCarryFlag;
      logic carry;
   } subw_flags_t;

   localparam subw_flags_t FLAGS_RST = '0;

   typedef struct packed {
      logic              toFile;
      logic [ADDR_W-1:0] addr;
   } subw_op_t;
endpackage
`default_nettype wire

// File: sim/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import subw_pkg::*;

   logic                 core_clk;
   logic                 rstn;
   logic [15:0]          instrWord;
   logic                 instrValid;
   logic                 extSetEn;
   logic [BANK_W-1:0]    bankPtr;
   logic [ADDR_W-1:0]    indexBase;
   logic                 wregLoad;
   logic [DATA_W-1:0]    wregLoadData;
   logic                 fileLoad;
   logic [ADDR_W-1:0]    fileLoadAddr;
   logic [DATA_W-1:0]    fileLoadData;
   logic [ADDR_W-1:0]    peekAddr;
   logic [DATA_W-1:0]    peekData;
   logic [DATA_W-1:0]    wregValue;
   subw_flags_t          statusFlags;
   subw_phase_t          phase;
   logic                 instrReady;
   logic                 instrDone;
   logic                 instrRejected;
   int                   n_mismatch = 0;
   int                   samples_checked = 0;
   int                   cycles = 0;

   subw_core subw_core_i (.core_clk(core_clk), .rstn(rstn), .instrWord(instrWord),
      .instrValid(instrValid), .extSetEn(extSetEn), .bankPtr(bankPtr),
      .indexBase(indexBase), .wregLoad(wregLoad), .wregLoadData(wregLoadData),
      .fileLoad(fileLoad), .fileLoadAddr(fileLoadAddr), .fileLoadData(fileLoadData),
      .peekAddr(peekAddr), .peekData(peekData), .wregValue(wregValue),
      .statusFlags(statusFlags), .phase(phase), .instrReady(instrReady),
      .instrDone(instrDone), .instrRejected(instrRejected));

   initial core_clk = 1'b0;
   always #10 core_clk = ~core_clk;

   task automatic results();
      $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // generous ceiling: the whole sequence needs about a hundred cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // phase runs free, so an issue must wait for the decode slot
   task automatic waitReady();
      int k;
      k = 0;
      while (instrReady !== 1'b1 && k < 8) begin
         @(negedge core_clk);
         k++;
      end
      check(instrReady, 1'b1);
   endtask

   task automatic runOp(input logic d, input logic a, input logic [7:0] f,
                        input logic [11:0] addr, input logic [7:0] fv,
                        input logic [7:0] wv);
      logic [7:0]  diff;
      subw_flags_t ef;
      @(negedge core_clk);
      fileLoad = 1'b1;
      fileLoadAddr = addr;
      fileLoadData = fv;
      wregLoad = 1'b1;
      wregLoadData = wv;
      @(negedge core_clk);
      fileLoad = 1'b0;
      wregLoad = 1'b0;
      waitReady();
      instrValid = 1'b1;
      instrWord = {OPC_SUBTRACT, d, a, f};
      @(negedge core_clk);
      instrValid = 1'b0;
      repeat (3) @(negedge core_clk);
      check(instrDone, 1'b1);
      check(instrReady, 1'b1);
      diff = fv - wv;
      ef.negative = diff[7];
      ef.overflowFlag = (fv[7] != wv[7]) && (diff[7] != fv[7]);
      ef.zero = (diff == 8'h00);
      ef.digitCarryFlag = (fv[3:0] >= wv[3:0]);
      ef.carry = (fv >= wv);
      check(wregValue, d ? wv : diff);
      check(statusFlags, ef);
      peekAddr = addr;
      @(negedge core_clk);
      check(peekData, d ? diff : fv);
   endtask

   task automatic rejectOp();
      logic [7:0] wBefore;
      waitReady();
      wBefore = wregValue;
      instrValid = 1'b1;
      instrWord = {6'h16, 2'b00, 8'h10};
      @(negedge core_clk);
      instrValid = 1'b0;
      check(instrRejected, 1'b1);
      repeat (5) @(negedge core_clk);
      check(instrDone, 1'b0);
      check(wregValue, wBefore);
   endtask

   // a valid op held only outside the decode slot must be ignored
   task automatic ignoreOp();
      logic [7:0] wBefore;
      waitReady();
      @(negedge core_clk);
      wBefore = wregValue;
      instrValid = 1'b1;
      instrWord = {OPC_SUBTRACT, 2'b01, 8'h10};
      repeat (3) @(negedge core_clk);
      instrValid = 1'b0;
      repeat (5) begin
         @(negedge core_clk);
         check(instrDone, 1'b0);
         check(instrRejected, 1'b0);
      end
      check(wregValue, wBefore);
   endtask

   initial begin
      rstn = 1'b0;
      instrWord = 16'h0000;
      instrValid = 1'b0;
      extSetEn = 1'b0;
      bankPtr = 4'h5;
      indexBase = 12'h0300;
      wregLoad = 1'b0;
      wregLoadData = 8'h00;
      fileLoad = 1'b0;
      fileLoadAddr = 12'h0000;
      fileLoadData = 8'h00;
      peekAddr = 12'h0000;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      check(wregValue, WREG_RST);
      check(statusFlags, FLAGS_RST);
      check(phase, PH_DECODE);
      rstn = 1'b1;
      runOp(1'b1, 1'b0, 8'h10, 12'h010, 8'h03, 8'h02);
      runOp(1'b0, 1'b0, 8'h10, 12'h010, 8'h02, 8'h02);
      runOp(1'b1, 1'b0, 8'h10, 12'h010, 8'h01, 8'h02);
      runOp(1'b0, 1'b0, 8'h90, 12'hF90, 8'h80, 8'h01);
      runOp(1'b1, 1'b1, 8'h20, 12'h520, 8'h35, 8'h17);
      extSetEn = 1'b1;
      runOp(1'b1, 1'b0, 8'h5F, 12'h35F, 8'h44, 8'h0A);
      runOp(1'b0, 1'b0, 8'h60, 12'h060, 8'h07, 8'h7F);
      runOp(1'b1, 1'b1, 8'h10, 12'h510, 8'h7F, 8'hFF);
      rejectOp();
      ignoreOp();
      results();
   end
endmodule
`default_nettype wire
